/* rtl/sixbit_port_pkg.sv */
package sixbit_port_pkg;

  localparam int          PIN_COUNT       = 6;
  localparam int          SYNC_STAGES     = 3;
  localparam int          SE_LOW_PIN_LSB  = 4;

  localparam logic [31:0] OFF_VALUE       = 32'h0000_0000;
  localparam logic [31:0] OFF_DIRECTION   = 32'h0000_0004;
  localparam logic [31:0] OFF_SE_32_39    = 32'h0000_0008;
  localparam logic [31:0] OFF_SE_40_41    = 32'h0000_000C;
  localparam logic [31:0] OFF_LATCH       = 32'h0000_0010;

  localparam logic [5:0]  DIR_RESET       = 6'h3F;
  localparam logic [5:0]  LATCH_RESET     = 6'h00;
  localparam logic [7:0]  SE_32_39_RESET  = 8'h00;
  localparam logic [1:0]  SE_40_41_RESET  = 2'h0;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_DECERR     = 2'h3;

  typedef enum logic [2:0] {
    SEL_VALUE,
    SEL_DIRECTION,
    SEL_SE_32_39,
    SEL_SE_40_41,
    SEL_LATCH,
    SEL_NONE
  } reg_sel_t;

  function automatic reg_sel_t reg_sel(input logic [31:0] addr);
    reg_sel_t sel;
    case ({addr[31:2], 2'h0})
      OFF_VALUE:     sel = SEL_VALUE;
      OFF_DIRECTION: sel = SEL_DIRECTION;
      OFF_SE_32_39:  sel = SEL_SE_32_39;
      OFF_SE_40_41:  sel = SEL_SE_40_41;
      OFF_LATCH:     sel = SEL_LATCH;
      default:       sel = SEL_NONE;
    endcase
    return sel;
  endfunction

endpackage

/* rtl/pin_input_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_input_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] level_q
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
    end else begin
      stage1_q <= raw_in;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // A bit moves only once two settled stages agree, filtering one-cycle glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_q[i] == stage3_q[i]) begin
          level_q[i] <= stage3_q[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

/* rtl/sixbit_lcd_port.sv */
// What this block does
// R1: Six port pins, bits 5 to 0, each set to input or output by its own direction bit.
// R2: A direction bit at one makes its pin a tri-stated input, and all six leave every reset at one.
// R3: A direction bit at zero enables the pin's output driver.
// R4: Reading the port value returns each pin's present input level, one for high, zero for low.
// R5: Bits 7 and 6 of the value and direction registers ignore writes and read as zero.
// R6: The output latch is set only at power-on and kept on other resets, as are the segment enables.
// R7: Pins 0 to 5 are shared in order with LCD segments 36 to 41.
// R8: Only bits 1 and 0 of the segment 40 to 41 enable register exist; the rest read as zero.
// R9: An enabled segment takes over its pin, and a value write loads the output latch.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module sixbit_lcd_port #(
  parameter int PINS = 6
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        warm_reset,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [5:0]  pin_in,
  output logic      [5:0]  pin_out,
  output logic      [5:0]  pin_oe,
  input  wire logic [5:0]  lcd_seg_level,
  output logic      [7:0]  seg_enable_32_39,
  output logic      [1:0]  seg_enable_40_41
);

  logic [31:0]                 awaddr_q;
  logic                        aw_full_q;
  logic                        aw_full_d;
  logic [31:0]                 wdata_q;
  logic                        wstrb0_q;
  logic                        w_full_q;
  logic                        w_full_d;
  logic                        wr_fire;
  logic                        wr_en;
  sixbit_port_pkg::reg_sel_t   wr_sel;
  logic                        bvalid_d;
  logic                        ar_fire;
  logic                        rvalid_d;
  sixbit_port_pkg::reg_sel_t   rd_sel;
  logic [31:0]                 rd_word;

  logic [5:0]                  dir_q;
  logic [5:0]                  latch_q;
  logic [7:0]                  se_low_q;
  logic [1:0]                  se_high_q;
  logic [5:0]                  seg_pins;
  logic [5:0]                  pin_sync;

  pin_input_sync #(
    .WIDTH   (PINS)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw_in  (pin_in),
    .level_q (pin_sync)
  );

  // Write channel: address and data are taken independently, in either order
  assign wr_fire  = aw_full_q && w_full_q && !bvalid;
  assign wr_sel   = sixbit_port_pkg::reg_sel(awaddr_q);
  assign wr_en    = wr_fire && wstrb0_q;

  always_comb begin
    aw_full_d = aw_full_q;
    if (wr_fire) begin
      aw_full_d = 1'b0;
    end
    if (awvalid && awready) begin
      aw_full_d = 1'b1;
    end
  end

  always_comb begin
    w_full_d = w_full_q;
    if (wr_fire) begin
      w_full_d = 1'b0;
    end
    if (wvalid && wready) begin
      w_full_d = 1'b1;
    end
  end

  always_comb begin
    bvalid_d = bvalid;
    if (bvalid && bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      bvalid_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awready   <= 1'b0;
      awaddr_q  <= 32'h0000_0000;
    end else begin
      aw_full_q <= aw_full_d;
      awready   <= !aw_full_d;
      if (awvalid && awready) begin
        awaddr_q <= awaddr;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wready   <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
    end else begin
      w_full_q <= w_full_d;
      wready   <= !w_full_d;
      if (wvalid && wready) begin
        wdata_q  <= wdata;
        wstrb0_q <= wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= sixbit_port_pkg::RESP_OKAY;
    end else begin
      bvalid <= bvalid_d;
      if (wr_fire) begin
        bresp <= (wr_sel == sixbit_port_pkg::SEL_NONE) ? sixbit_port_pkg::RESP_DECERR
                                                      : sixbit_port_pkg::RESP_OKAY;
      end
    end
  end

  // Direction: every reset, warm or power-on, returns all pins without an enabled segment to inputs
  always_ff @(posedge aclk) begin
    if (!aresetn || warm_reset) begin
      dir_q <= sixbit_port_pkg::DIR_RESET; // [R2]
    end else if (wr_en && wr_sel == sixbit_port_pkg::SEL_DIRECTION) begin
      dir_q <= wdata_q[5:0]; // [R1] [R5]
    end
  end

  // Latch and segment enables ignore the warm reset so latch levels and segment-driven pins survive it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_q <= sixbit_port_pkg::LATCH_RESET; // [R6]
    end else if (wr_en && wr_sel == sixbit_port_pkg::SEL_VALUE) begin
      latch_q <= wdata_q[5:0]; // [R9] [R5]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      se_low_q  <= sixbit_port_pkg::SE_32_39_RESET; // [R6]
      se_high_q <= sixbit_port_pkg::SE_40_41_RESET; // [R6]
    end else begin
      if (wr_en && wr_sel == sixbit_port_pkg::SEL_SE_32_39) begin
        se_low_q <= wdata_q[7:0];
      end
      if (wr_en && wr_sel == sixbit_port_pkg::SEL_SE_40_41) begin
        se_high_q <= wdata_q[1:0]; // [R8]
      end
    end
  end

  // Segments 36..39 sit in the upper half of the low enable register
  assign seg_pins = {se_high_q, se_low_q[7:sixbit_port_pkg::SE_LOW_PIN_LSB]}; // [R7]

  // Pin drivers are registered so no enable glitch reaches the pads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe  <= 6'h00;
      pin_out <= 6'h00;
    end else begin
      pin_oe  <= seg_pins | ~dir_q; // [R2] [R3] [R9]
      pin_out <= (seg_pins & lcd_seg_level) | (~seg_pins & latch_q); // [R7] [R9]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seg_enable_32_39 <= sixbit_port_pkg::SE_32_39_RESET;
      seg_enable_40_41 <= sixbit_port_pkg::SE_40_41_RESET;
    end else begin
      seg_enable_32_39 <= se_low_q;
      seg_enable_40_41 <= se_high_q;
    end
  end

  // Read channel: one read at a time, answered one cycle after the address
  assign ar_fire = arvalid && arready;
  assign rd_sel  = sixbit_port_pkg::reg_sel(araddr);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_sel)
      sixbit_port_pkg::SEL_VALUE:     rd_word[5:0] = pin_sync; // [R4] [R5]
      sixbit_port_pkg::SEL_DIRECTION: rd_word[5:0] = dir_q; // [R5]
      sixbit_port_pkg::SEL_SE_32_39:  rd_word[7:0] = se_low_q;
      sixbit_port_pkg::SEL_SE_40_41:  rd_word[1:0] = se_high_q; // [R8]
      sixbit_port_pkg::SEL_LATCH:     rd_word[5:0] = latch_q;
      default:                        rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    rvalid_d = rvalid;
    if (rvalid && rready) begin
      rvalid_d = 1'b0;
    end
    if (ar_fire) begin
      rvalid_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid  <= 1'b0;
      arready <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= sixbit_port_pkg::RESP_OKAY;
    end else begin
      rvalid  <= rvalid_d;
      arready <= !rvalid_d;
      if (ar_fire) begin
        rdata <= rd_word;
        rresp <= (rd_sel == sixbit_port_pkg::SEL_NONE) ? sixbit_port_pkg::RESP_DECERR
                                                      : sixbit_port_pkg::RESP_OKAY;
      end
    end
  end

  default clocking cb @(posedge aclk);
  endclocking

  default disable iff (!aresetn);

  chk_dir_after_reset: assert property ( // [R2]
    (!$past(aresetn) || $past(warm_reset)) |-> dir_q == sixbit_port_pkg::DIR_RESET
  ) else $error("direction not all inputs after reset");

  chk_input_tristated: assert property ( // [R2]
    $past(aresetn) |-> (pin_oe & $past(dir_q & ~seg_pins)) == 6'h00
  ) else $error("input pin driven");

  chk_output_driven: assert property ( // [R3]
    $past(aresetn) |-> (pin_oe & $past(~dir_q)) == $past(~dir_q)
  ) else $error("output pin not driven");

  chk_value_read: assert property ( // [R4]
    ar_fire && rd_sel == sixbit_port_pkg::SEL_VALUE
    |=> rvalid && rdata == {26'h0, $past(pin_sync)}
  ) else $error("value read does not show pin levels");

  chk_dir_read_upper: assert property ( // [R5]
    ar_fire && rd_sel == sixbit_port_pkg::SEL_DIRECTION
    |=> rdata == {26'h0, $past(dir_q)}
  ) else $error("direction read wrong or upper bits set");

  chk_warm_keeps_state: assert property ( // [R6]
    warm_reset && !wr_fire
    |=> latch_q == $past(latch_q) && se_low_q == $past(se_low_q) && se_high_q == $past(se_high_q)
  ) else $error("warm reset disturbed latch or segments");

  chk_seg_takeover: assert property ( // [R7]
    $past(aresetn) |-> (pin_oe & $past(seg_pins)) == $past(seg_pins)
      && (pin_out & $past(seg_pins)) == $past(seg_pins & lcd_seg_level)
  ) else $error("segment did not take over pin");

  chk_seg_high_read: assert property ( // [R8]
    ar_fire && rd_sel == sixbit_port_pkg::SEL_SE_40_41 |=> rdata == {30'h0, $past(se_high_q)}
  ) else $error("segment 40-41 read shows unimplemented bits");

  chk_latch_write: assert property ( // [R9]
    wr_en && wr_sel == sixbit_port_pkg::SEL_VALUE |=> latch_q == $past(wdata_q[5:0])
  ) else $error("value write did not load latch");

  chk_output_level: assert property ( // [R9]
    $past(aresetn) ##1 1'b1 |-> (pin_out & $past(~seg_pins)) == $past(latch_q & ~seg_pins)
  ) else $error("output pin level differs from latch");

  chk_bvalid_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp)
  ) else $error("write response dropped early");

  chk_write_answer: assert property (
    wr_fire |=> bvalid [*1] ##0 (awready || aw_full_q)
  ) else $error("write response missing");

  chk_dir_write: assert property ( // [R1]
    wr_en && wr_sel == sixbit_port_pkg::SEL_DIRECTION && !warm_reset
    |=> dir_q == $past(wdata_q[5:0])
  ) else $error("direction write not applied");

  chk_seg_low_read: assert property ( // [R7]
    ar_fire && rd_sel == sixbit_port_pkg::SEL_SE_32_39 |=> rdata == {24'h0, $past(se_low_q)}
  ) else $error("segment 32-39 read wrong");

  chk_seg_high_write: assert property ( // [R8]
    wr_en && wr_sel == sixbit_port_pkg::SEL_SE_40_41 |=> se_high_q == $past(wdata_q[1:0])
  ) else $error("segment 40-41 write not applied");

  chk_latch_read_only: assert property ( // [R9]
    wr_en && wr_sel == sixbit_port_pkg::SEL_LATCH |=> latch_q == $past(latch_q)
  ) else $error("latch readback location accepted a write");

  chk_latch_read: assert property ( // [R9]
    ar_fire && rd_sel == sixbit_port_pkg::SEL_LATCH |=> rdata == {26'h0, $past(latch_q)}
  ) else $error("latch readback wrong");

  chk_seg_copy: assert property ( // [R7]
    $past(aresetn)
    |-> seg_enable_32_39 == $past(se_low_q) && seg_enable_40_41 == $past(se_high_q)
  ) else $error("segment enable copy differs");

  chk_strobe_gates: assert property (
    wr_fire && !wstrb0_q && !warm_reset
    |=> $stable(dir_q) && $stable(latch_q) && $stable(se_low_q) && $stable(se_high_q)
  ) else $error("write without byte 0 strobe changed a register");

  chk_unmapped_write: assert property (
    wr_fire && wr_sel == sixbit_port_pkg::SEL_NONE
    |=> bvalid && bresp == sixbit_port_pkg::RESP_DECERR
  ) else $error("unmapped write not refused");

  chk_rvalid_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp)
  ) else $error("read data dropped early");

  chk_read_answer: assert property (
    ar_fire |=> rvalid && !arready
  ) else $error("read answer missing");

endmodule

`default_nettype wire

/* verification/pin_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_pad_model (
  input  wire logic       aclk,
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] ext_en,
  input  wire logic [5:0] ext_level,
  output logic      [5:0] pad
);
  logic [5:0] float_q = 6'h00;

  // Undriven pads wander so a stale level never passes for input
  always_ff @(posedge aclk) begin
    float_q <= ~pad;
  end

  // Device driver owns the pad while enabled, else the outside world
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pin_oe[i]) pad[i] = pin_out[i];
      else if (ext_en[i]) pad[i] = ext_level[i];
      else pad[i] = float_q[i];
    end
  end
endmodule

`default_nettype wire

/* verification/six_bit_lcd_shared_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end

module six_bit_lcd_shared_port_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        warm_reset = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [5:0]  pin_in, pin_out, pin_oe;
  logic [5:0]  lcd_seg_level = 6'h00, ext_en = 6'h00, ext_level = 6'h00;
  logic [7:0]  seg_enable_32_39;
  logic [1:0]  seg_enable_40_41;
  int          miscompares = 0;
  int          total_checks = 0;

  always #5 aclk = ~aclk;

  sixbit_lcd_port sixbit_lcd_port_i (
    .aclk(aclk), .aresetn(aresetn), .warm_reset(warm_reset),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .lcd_seg_level(lcd_seg_level),
    .seg_enable_32_39(seg_enable_32_39), .seg_enable_40_41(seg_enable_40_41)
  );

  pin_pad_model pin_pad_model_i (
    .aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .ext_en(ext_en), .ext_level(ext_level), .pad(pin_in)
  );

  // No cycle limit here: only the watchdog may end a wait
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er,
                    input logic [3:0] s = 4'hF);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw_done && awready) begin awvalid <= 1'b0; aw_done = 1; end
      if (!w_done && wready) begin wvalid <= 1'b0; w_done = 1; end
    end while (!(bvalid && aw_done && w_done));
    `CHK(bresp, er)
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit ar_done;
    ar_done = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!ar_done && arready) begin arvalid <= 1'b0; ar_done = 1; end
    end while (!(rvalid && ar_done));
    `CHK(rdata, ed)
    `CHK(rresp, er)
    rready <= 1'b0;
  endtask

  // Register edge plus one edge to the pads, then let updates land
  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  localparam logic [1:0] OK = sixbit_port_pkg::RESP_OKAY;
  localparam logic [1:0] DE = sixbit_port_pkg::RESP_DECERR;

  initial begin
    repeat (5000) @(posedge aclk);
    $display("BAD t=%0t watchdog expired", $time);
    miscompares++;
    wrap_up();
  end

  initial begin
    logic [5:0] m;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    `CHK(pin_oe, 6'h00)
    rd(sixbit_port_pkg::OFF_DIRECTION, 32'h0000_003F, OK);
    rd(sixbit_port_pkg::OFF_SE_32_39, 32'h0000_0000, OK);
    rd(sixbit_port_pkg::OFF_SE_40_41, 32'h0000_0000, OK);
    rd(sixbit_port_pkg::OFF_LATCH, 32'h0000_0000, OK);
    rd(32'h0000_0020, 32'h0000_0000, DE);
    wr(32'h0000_0020, 32'h0000_00FF, DE);
    wr(sixbit_port_pkg::OFF_DIRECTION, 32'h0000_0000, OK, 4'hE);
    rd(sixbit_port_pkg::OFF_DIRECTION, 32'h0000_003F, OK);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      m = 6'(1 << i);
      wr(sixbit_port_pkg::OFF_DIRECTION, {26'h0, ~m}, OK);
      settle();
      `CHK(pin_oe, m)
    end
    wr(sixbit_port_pkg::OFF_DIRECTION, 32'h0000_00FF, OK);
    rd(sixbit_port_pkg::OFF_DIRECTION, 32'h0000_003F, OK);
    $display("test direction done");
    wr(sixbit_port_pkg::OFF_VALUE, 32'h0000_00EA, OK);
    rd(sixbit_port_pkg::OFF_LATCH, 32'h0000_002A, OK);
    wr(sixbit_port_pkg::OFF_LATCH, 32'h0000_003F, OK);
    rd(sixbit_port_pkg::OFF_LATCH, 32'h0000_002A, OK);
    wr(sixbit_port_pkg::OFF_DIRECTION, 32'h0000_0000, OK);
    settle();
    `CHK(pin_oe, 6'h3F)
    `CHK(pin_out, 6'h2A)
    repeat (8) @(posedge aclk);
    rd(sixbit_port_pkg::OFF_VALUE, 32'h0000_002A, OK);
    $display("test output done");
    wr(sixbit_port_pkg::OFF_DIRECTION, 32'h0000_003F, OK);
    ext_en <= 6'h3F;
    ext_level <= 6'h15;
    repeat (8) @(posedge aclk);
    rd(sixbit_port_pkg::OFF_VALUE, 32'h0000_0015, OK);
    ext_level <= 6'h2A;
    repeat (8) @(posedge aclk);
    rd(sixbit_port_pkg::OFF_VALUE, 32'h0000_002A, OK);
    ext_en <= 6'h00;
    $display("test input done");
    lcd_seg_level <= 6'h15;
    for (int i = 0; i < 6; i++) begin
      m = 6'(1 << i);
      wr(sixbit_port_pkg::OFF_SE_32_39, {24'h0, m[3:0], 4'h0}, OK);
      wr(sixbit_port_pkg::OFF_SE_40_41, {30'h0, m[5:4]}, OK);
      settle();
      `CHK(pin_oe, m)
      `CHK(pin_out, (6'h2A & ~m) | (6'h15 & m))
      `CHK({seg_enable_40_41, seg_enable_32_39[7:4]}, m)
    end
    wr(sixbit_port_pkg::OFF_SE_40_41, 32'h0000_00FF, OK);
    rd(sixbit_port_pkg::OFF_SE_40_41, 32'h0000_0003, OK);
    wr(sixbit_port_pkg::OFF_SE_32_39, 32'h0000_000F, OK);
    rd(sixbit_port_pkg::OFF_SE_32_39, 32'h0000_000F, OK);
    settle();
    `CHK(seg_enable_32_39, 8'h0F)
    `CHK(pin_oe, 6'h30)
    `CHK(pin_out, 6'h1A)
    $display("test segments done");
    wr(sixbit_port_pkg::OFF_DIRECTION, 32'h0000_0000, OK);
    @(posedge aclk);
    warm_reset <= 1'b1;
    @(posedge aclk);
    warm_reset <= 1'b0;
    rd(sixbit_port_pkg::OFF_DIRECTION, 32'h0000_003F, OK);
    rd(sixbit_port_pkg::OFF_LATCH, 32'h0000_002A, OK);
    rd(sixbit_port_pkg::OFF_SE_40_41, 32'h0000_0003, OK);
    $display("test warm reset done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    `CHK(pin_oe, 6'h00)
    rd(sixbit_port_pkg::OFF_SE_32_39, 32'h0000_0000, OK);
    rd(sixbit_port_pkg::OFF_SE_40_41, 32'h0000_0000, OK);
    rd(sixbit_port_pkg::OFF_DIRECTION, 32'h0000_003F, OK);
    $display("test power-on reset done");
    wrap_up();
  end
endmodule

`default_nettype wire
